/* File: inc/stack_limit_pkg.sv */
// Behaviour
// - One working register doubles as stack pointer
// - Pointer addresses first free word, grows upward
// - Push writes then increments; pop decrements then reads
// - Pushed program counter has top bit cleared
// - Limit register uninitialised by reset
// - Bit 0 of pointer and limit forced zero
// - Only push addresses compared with limit; every checked address compared with floor
// - Push at limit passes; next push traps
// - Checked address below floor raises underflow trap
package stack_limit_pkg;
    localparam int DATA_W = 16;
    localparam logic [15:0] STACK_FLOOR = 16'h0800;
    localparam logic [15:0] WORD_STEP = 16'h0002;
    localparam logic [15:0] POINTER_RESET = 16'h0800;
    localparam int ALIGN_BIT = 0;
    localparam int PC_TOP_BIT = 15;

    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_PUSH = 2'b01,
        OP_POP = 2'b10,
        OP_WRITE = 2'b11
    } stack_op_t;
endpackage

/* File: rtl/stack_bound_compare.sv */
`timescale 1ns/100ps
module stack_bound_compare
    import stack_limit_pkg::*;
(
    input wire logic [15:0] address,
    input wire logic [15:0] limit,
    input wire logic isPush,
    output logic overLimit,
    output logic belowFloor
);
    // Push at the limit itself is allowed; only beyond it traps
    always_comb begin
        overLimit = isPush && (address > limit);
        belowFloor = address < STACK_FLOOR;
    end
endmodule

/* File: rtl/stack_limit_checker.sv */
`timescale 1ns/100ps
module stack_limit_checker
    import stack_limit_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [1:0] stackOp,
    input wire logic [15:0] opData,
    input wire logic isCallPush,
    input wire logic limitWrite,
    input wire logic [15:0] limitData,
    input wire logic eaValid,
    input wire logic [15:0] eaAddress,
    output logic [15:0] stackPointer,
    output logic [15:0] stackLimit,
    output logic [15:0] memAddress,
    output logic [15:0] memWriteData,
    output logic memWrite,
    output logic memRead,
    output logic stackErrorTrap
);
    stack_op_t opCode;
    logic [15:0] stack_pointer_reg;
    logic [15:0] stack_limit_reg;
    logic [15:0] next_pointer;
    logic [15:0] checkAddress;
    logic [15:0] alignedData;
    logic [15:0] alignedLimit;
    logic [15:0] alignedEa;
    logic [15:0] pushedWord;
    logic opPush;
    logic opPop;
    logic opWrite;
    logic eaCheck;
    logic checkValid;
    logic overLimit;
    logic belowFloor;
    logic limitKnown;
    logic limitTrap;
    logic next_trap;

    // Step and alignment bit must agree, or a push would straddle two words
    if (DATA_W != 16 || WORD_STEP != (16'h0002 << ALIGN_BIT)) begin : g_step_check
        $error("stack step does not fit the 16-bit word layout");
    end

    // The return-address clear assumes the top bit of a 16-bit word
    if (PC_TOP_BIT != DATA_W - 1) begin : g_pc_check
        $error("program counter top bit outside the data word");
    end

    // Bit 0 is dropped on every path into the pointer, limit or check address
    for (genvar b = 0; b < DATA_W; b++) begin : g_align
        if (b == ALIGN_BIT) begin : g_low
            assign alignedData[b] = 1'b0;
            assign alignedLimit[b] = 1'b0;
            assign alignedEa[b] = 1'b0;
        end else begin : g_pass
            assign alignedData[b] = opData[b];
            assign alignedLimit[b] = limitData[b];
            assign alignedEa[b] = eaAddress[b];
        end
    end

    assign opCode = stack_op_t'(stackOp);

    // A pointer-based address is only checked in a cycle without a stack operation
    always_comb begin
        opPush = 1'b0;
        opPop = 1'b0;
        opWrite = 1'b0;
        eaCheck = 1'b0;
        case (opCode)
            OP_NONE: begin
                eaCheck = eaValid;
            end
            OP_PUSH: begin
                opPush = 1'b1;
            end
            OP_POP: begin
                opPop = 1'b1;
            end
            OP_WRITE: begin
                opWrite = 1'b1;
            end
            default: begin
                eaCheck = 1'b0;
            end
        endcase
    end

    // Pointer always names the first free word
    always_comb begin
        next_pointer = stack_pointer_reg;
        if (opPush) begin
            next_pointer = stack_pointer_reg + WORD_STEP;
        end else if (opPop) begin
            next_pointer = stack_pointer_reg - WORD_STEP;
        end else if (opWrite) begin
            next_pointer = alignedData;
        end
    end

    // Push checks the word it writes, pop the word it reads back
    always_comb begin
        checkAddress = alignedEa;
        if (opPush) begin
            checkAddress = stack_pointer_reg;
        end else if (opPop) begin
            checkAddress = stack_pointer_reg - WORD_STEP;
        end
    end

    assign checkValid = opPush || opPop || eaCheck;

    // A pushed return address never carries its top bit
    always_comb begin
        pushedWord = opData;
        if (isCallPush) begin
            pushedWord = {1'b0, opData[PC_TOP_BIT-1:0]};
        end
    end

    stack_bound_compare compare (
        .address(checkAddress),
        .limit(stack_limit_reg),
        .isPush(opPush),
        .overLimit(overLimit),
        .belowFloor(belowFloor)
    );

    // Before the first limit write the bound is unknown; only the floor counts
    always_comb begin
        limitTrap = limitKnown && overLimit;
        next_trap = 1'b0;
        if (checkValid) begin
            next_trap = belowFloor || limitTrap;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            stack_pointer_reg <= POINTER_RESET;
        end else begin
            stack_pointer_reg <= next_pointer;
        end
    end

    // No reset on the limit value: undefined until software writes it
    always_ff @(posedge sys_clk) begin
        if (limitWrite) begin
            stack_limit_reg <= alignedLimit;
        end
    end

    // Limit checks stay quiet until the limit holds a defined value
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            limitKnown <= 1'b0;
        end else if (limitWrite) begin
            limitKnown <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            stackErrorTrap <= 1'b0;
        end else begin
            stackErrorTrap <= next_trap;
        end
    end

    // Strobes last exactly one cycle per operation
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            memWrite <= 1'b0;
        end else begin
            memWrite <= opPush;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            memRead <= 1'b0;
        end else begin
            memRead <= opPop;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            memAddress <= 16'h0000;
        end else begin
            memAddress <= checkAddress;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            memWriteData <= 16'h0000;
        end else begin
            memWriteData <= pushedWord;
        end
    end

    // Separate copy so the output comes straight from its own flop
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            stackPointer <= POINTER_RESET;
        end else begin
            stackPointer <= next_pointer;
        end
    end

    // Readback shows a write one cycle later and reads zero until then
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            stackLimit <= 16'h0000;
        end else if (limitWrite) begin
            stackLimit <= alignedLimit;
        end
    end
endmodule

/* File: verification/stack_limit_checker_assertions.sv */
`timescale 1ns/100ps
module stack_limit_checker_assertions (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic isCallPush,
    input wire logic limitWrite,
    input wire logic eaValid,
    input wire logic memWrite,
    input wire logic memRead,
    input wire logic stackErrorTrap,
    input wire logic [1:0] stackOp,
    input wire logic [15:0] opData,
    input wire logic [15:0] limitData,
    input wire logic [15:0] eaAddress,
    input wire logic [15:0] stackPointer,
    input wire logic [15:0] stackLimit,
    input wire logic [15:0] memAddress,
    input wire logic [15:0] memWriteData
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    AST_PUSH: assert property (stackOp == 1 |=> memWrite &&
        memAddress == $past(stackPointer) && stackPointer == memAddress + 16'h2) else $error("push");
    AST_POP: assert property (stackOp == 2 |=> memRead &&
        stackPointer == memAddress && memAddress == $past(stackPointer) - 16'h2) else $error("pop");
    AST_CALL: assert property (stackOp == 1 && isCallPush |=> !memWriteData[15])
        else $error("call");
    AST_ALIGN: assert property (!stackPointer[0] && !stackLimit[0]) else $error("align");
    AST_LIM: assert property (limitWrite |=>
        stackLimit == ($past(limitData) & 16'hFFFE)) else $error("lim");
    AST_FLOOR: assert property (stackOp == 2 && stackPointer == 16'h0800 |=>
        stackErrorTrap) else $error("floor");
    AST_EA: assert property (stackOp == 0 && eaValid && eaAddress < 16'h0800 |=>
        stackErrorTrap) else $error("ea");
    AST_QUIET: assert property (stackOp == 0 && !eaValid |=>
        !stackErrorTrap && !memWrite && !memRead) else $error("quiet");
endmodule
bind stack_limit_checker stack_limit_checker_assertions i_chk (.*);

/* File: verification/stack_mem_model.sv */
`timescale 1ns/100ps
module stack_mem_model (
    input wire logic sys_clk,
    input wire logic memWrite,
    input wire logic [15:0] memAddress,
    input wire logic [15:0] memWriteData,
    output logic [15:0] readData
);
    logic [15:0] mem [0:32767];
    // Word store, bit 0 never picks a byte
    always @(posedge sys_clk) if (memWrite) mem[memAddress[15:1]] <= memWriteData;
    assign readData = mem[memAddress[15:1]];
endmodule

/* File: verification/test_stack_limit_checker.sv */
`timescale 1ns/100ps
module test_stack_limit_checker;
    logic sys_clk = 0, reset_n = 0, isCallPush = 0, limitWrite = 0, eaValid = 0;
    logic [1:0] stackOp = 0;
    logic [15:0] opData = 0, limitData = 0, eaAddress = 0, lfsr = 16'hA78F;
    wire logic [15:0] stackPointer, stackLimit, memAddress, memWriteData, readData;
    wire logic memWrite, memRead, stackErrorTrap;
    int fails = 0, check_count = 0;
    logic [15:0] q[$];
    stack_limit_checker i_dut (.*);
    stack_mem_model i_mem (.*);
    initial forever #20 sys_clk = ~sys_clk;
    function logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function logic [15:0] stored_word(input logic [15:0] v, input logic call);
        return call ? {1'b0, v[14:0]} : v;
    endfunction
    task chk(input logic [15:0] seen, want, input string what);
        check_count++;
        if (seen !== want) begin
            fails++;
            $display("CHECK FAILED %s exp %h seen %h", what, want, seen);
        end
    endtask
    task op(input logic [1:0] o, input logic [15:0] d, input logic c = 0, lw = 0, ev = 0);
        stackOp = o;
        opData = d;
        isCallPush = c;
        limitWrite = lw;
        limitData = d;
        eaValid = ev;
        eaAddress = d;
        @(posedge sys_clk);
        #1;
    endtask
    task conclude;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge sys_clk);
        #1 reset_n = 1;
        op(2, 16'h0000);
        chk(stackErrorTrap, 1'b1, "floor trap");
        chk(memAddress, 16'h07FE, "pop address");
        op(3, 16'h1FFF);
        chk(stackPointer, 16'h1FFE, "pointer write");
        op(0, 16'h1FFF, 0, 1);
        chk(stackLimit, 16'h1FFE, "limit readback");
        op(0, 16'h0000);
        op(1, 16'h0005);
        chk(stackErrorTrap, 1'b0, "push at limit");
        op(1, 16'h0006);
        chk(stackErrorTrap, 1'b1, "push over limit");
        op(0, 16'h07FE, 0, 0, 1);
        chk(stackErrorTrap, 1'b1, "address below floor");
        op(0, 16'h8001, 0, 0, 1);
        chk(stackErrorTrap, 1'b0, "high address");
        chk(memAddress, 16'h8000, "high address aligned");
        $display("corner cases done");
        op(3, 16'h1000);
        repeat (16) begin
            lfsr = nxt(lfsr);
            op(1, lfsr, lfsr[0]);
            chk(stackErrorTrap, 1'b0, "push in range");
            q.push_back(stored_word(lfsr, lfsr[0]));
        end
        repeat (16) begin
            op(2, 16'h0000);
            chk(readData, q.pop_back(), "pop data");
        end
        chk(stackPointer, 16'h1000, "pointer restored");
        $display("push pop sequence done");
        conclude();
    end
    initial begin
        #20000;
        fails++;
        conclude();
    end
endmodule
